// file: verilog/aeis_status.sv
// aeis_status: per-axis error status, interrupt factor and input levels,
// reached over apb. pins are asynchronous and pass two flip-flops.
// assumes the motion core drives its event struct on pclk.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`default_nettype none
module aeis_status
   import aeis_pkg::*;
#(
   parameter int unsigned SYNC_STAGES = 2
)(
   input  wire logic                pclk,          // apb clock
   input  wire logic                presetn,       // async reset, low
   input  wire logic                psel,          // apb select
   input  wire logic                penable,       // apb access phase
   input  wire logic                pwrite,        // apb direction
   input  wire logic [7:0]          paddr,         // apb byte address
   input  wire logic [31:0]         pwdata,        // apb write data
   input  wire logic [3:0]          pstrb,         // apb byte strobes
   output logic [31:0]              prdata,        // apb read data
   output logic                     pready,        // apb ready
   output logic                     pslverr,       // apb error
   input  wire aeis_core_t [1:0]    core,          // motion core events
   input  wire aeis_pins_t [1:0]    pins,          // raw axis pins
   input  wire logic                emergency_halt_input, // low = halt
   input  wire logic                subchip_fault_in, // sub chip error
   input  wire logic                is_main_chip,  // multichip main
   input  wire logic                bus8_mode,     // 8-bit host bus
   output aeis_stop_t [1:0]         stop_req,      // stop request
   output logic [1:0]               axis_err_flag, // error flag per axis
   output logic                     irq_out_low    // interrupt, low
);
   if (SYNC_STAGES != 2)
   begin : g_bad_sync
      $error("aeis_status: only two sync stages supported");
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   localparam int unsigned PW = $bits(aeis_pins_t) * 2 + 1;
   logic [PW-1:0] sync_a;
   logic [PW-1:0] sync_b;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // idle pin levels, so no error latches right after reset
         sync_a <= '1;
         sync_b <= '1;
      end
      else
      begin
         sync_a <= {emergency_halt_input, pins};
         sync_b <= sync_a;
      end
   end
   aeis_pins_t [1:0] pin_s;
   logic             emg_s;
   assign {emg_s, pin_s} = sync_b;

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  cmd_code;
   logic [1:0]  cmd_axes;
   logic        drive_cmd;
   logic        clear_cmd;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign cmd_code = pwdata[7:0];
   assign cmd_axes = pwdata[AEIS_CMD_AX_LSB+1:AEIS_CMD_AX_LSB];
   assign drive_cmd = wr_en && paddr == AEIS_CMD_ADDR && pstrb[0] &&
                      cmd_code >= AEIS_CMD_DRV_LO &&
                      cmd_code <= AEIS_CMD_DRV_HI;
   assign clear_cmd = wr_en && paddr == AEIS_CMD_ADDR && pstrb[0] &&
                      cmd_code == AEIS_CMD_CLEAR;

   function automatic logic mapped(input logic [7:0] a);
      mapped = a == AEIS_ERR_ADDR || a == AEIS_IRQF_ADDR ||
               a == AEIS_XIN_ADDR || a == AEIS_YIN_ADDR ||
               a == AEIS_CMD_ADDR || a == AEIS_IEN_ADDR ||
               a == AEIS_CFG_ADDR || a == AEIS_MAIN_ADDR;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // axis select and control registers
   logic        sel_axis;
   logic [15:0] irq_en;
   logic [15:0] cfg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sel_axis <= 1'b0;
      else if (wr_en && paddr == AEIS_CMD_ADDR && pstrb[1] &&
               cmd_axes != 2'b00)
         sel_axis <= cmd_axes == 2'b10;       // R10 R11
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_en <= {AEIS_IEN_RST, AEIS_IEN_RST};
         cfg    <= {AEIS_CFG_RST, AEIS_CFG_RST};
      end
      else if (wr_en)
      begin
         if (paddr == AEIS_IEN_ADDR)
         begin
            if (pstrb[0])
               irq_en[7:0] <= pwdata[7:0];
            if (pstrb[1])
               irq_en[15:8] <= pwdata[15:8];
         end
         if (paddr == AEIS_CFG_ADDR)
         begin
            if (pstrb[0])
               cfg[7:0] <= pwdata[7:0];
            if (pstrb[1])
               cfg[15:8] <= pwdata[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-axis error status and interrupt factors
   logic [1:0][15:0] err_stat;
   logic [1:0][15:0] irq_fac;
   logic [1:0]       fac_rd;
   logic             irqf_read;
   assign irqf_read = rd_en && paddr == AEIS_IRQF_ADDR &&
                      (bus8_mode || pstrb == 4'h0 || 1'b1);

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_axis
         logic [7:0]  c;
         logic        lmt_p;
         logic        lmt_n;
         logic        alm;
         logic [15:0] err_set;
         logic [15:0] fac_set;
         assign c = cfg[g*8 +: 8];
         assign lmt_p = pin_s[g].pos_limit_input == c[AEIS_CFG_LMT_HI];
         assign lmt_n = pin_s[g].neg_limit_input == c[AEIS_CFG_LMT_HI];
         assign alm = pin_s[g].servo_fault_input == c[AEIS_CFG_ALM_HI];
         always_comb
         begin
            err_set = 16'h0000;
            err_set[AEIS_E_SLP] = c[AEIS_CFG_SL_EN] && core[g].drv_pos &&
                                  core[g].ge_cpos;          // R2 R9
            err_set[AEIS_E_SLN] = c[AEIS_CFG_SL_EN] && core[g].drv_neg &&
                                  core[g].le_cneg;          // R3 R9
            err_set[AEIS_E_HLP] = lmt_p;                    // R4
            err_set[AEIS_E_HLN] = lmt_n;                    // R4
            err_set[AEIS_E_ALM] = alm;                      // R5
            err_set[AEIS_E_EMG] = !emg_s;                   // R6
            err_set[AEIS_E_SUB] = (g == 0) && is_main_chip &&
                                  subchip_fault_in;         // R7
         end
         always_comb
         begin
            fac_set = 16'h0000;
            fac_set[1] = core[g].gt_cneg_evt;               // R14
            fac_set[2] = core[g].lt_cneg_evt;
            fac_set[3] = core[g].lt_cpos_evt;
            fac_set[4] = core[g].gt_cpos_evt;
            fac_set[5] = core[g].cruise_end_evt;            // R15
            fac_set[6] = core[g].cruise_begin_evt;
            fac_set[7] = core[g].drive_done_evt;
            fac_set[7:0] = fac_set[7:0] & irq_en[g*8 +: 8]; // R13 R16
         end
         // set wins over the clear in the same cycle
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               err_stat[g] <= AEIS_ERR_RST;
            else if ((drive_cmd || clear_cmd) && cmd_axes[g])
               err_stat[g] <= err_set;                      // R12
            else
               err_stat[g] <= err_stat[g] | err_set;        // R1
         end
         assign fac_rd[g] = irqf_read && sel_axis == 1'(g);
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               irq_fac[g] <= AEIS_IRQF_RST;
            else if (fac_rd[g])
               irq_fac[g] <= fac_set;                       // R17 R18
            else
               irq_fac[g] <= irq_fac[g] | fac_set;
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               axis_err_flag[g] <= 1'b0;
               stop_req[g]      <= '0;
            end
            else
            begin
               axis_err_flag[g] <= |err_stat[g][6:0];       // R1
               stop_req[g].sudden <= (|err_set[3:0]) &&
                  (core[g].drv_pos || core[g].drv_neg) &&
                  c[AEIS_CFG_LMT_IMM];                      // R8
               stop_req[g].decel <= (|err_set[3:0]) &&
                  (core[g].drv_pos || core[g].drv_neg) &&
                  !c[AEIS_CFG_LMT_IMM];                     // R8
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // interrupt output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_out_low <= 1'b1;
      else
         irq_out_low <= !(|(irq_fac[0][7:0] & irq_en[7:0]) ||
                          |(irq_fac[1][7:0] & irq_en[15:8]));  // R16 R22
   end

   ////////////////////////////////////////////////////////////////////////
   // input level views
   function automatic logic [15:0] levels(input aeis_pins_t p,
                                          input logic emergency_halt_err);
      levels = {p.neg_limit_input, p.pos_limit_input, p.general_input,
                p.servo_fault_input, p.in_position_input,
                p.ext_drive_neg_input, p.ext_drive_pos_input,
                emergency_halt_err, p.stop_input};                          // R19 R20 R21
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb read and response
   logic [31:0] next_prdata;
   always_comb
   begin
      next_prdata = AEIS_UNMAPPED;
      unique case (paddr)
         AEIS_ERR_ADDR:  next_prdata = {16'h0000, err_stat[sel_axis]};
         AEIS_IRQF_ADDR: next_prdata = {16'h0000, irq_fac[sel_axis]};
         AEIS_XIN_ADDR:  next_prdata = {16'h0000, levels(pin_s[0], emg_s)};
         AEIS_YIN_ADDR:  next_prdata = {16'h0000, levels(pin_s[1], 1'b0)};
         AEIS_CMD_ADDR:  next_prdata = {31'h0, sel_axis};
         AEIS_IEN_ADDR:  next_prdata = {16'h0000, irq_en};
         AEIS_CFG_ADDR:  next_prdata = {16'h0000, cfg};
         AEIS_MAIN_ADDR: next_prdata = {30'h0, axis_err_flag};
         default:        next_prdata = AEIS_UNMAPPED;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         if (psel && !penable && !pwrite)
            prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

// file: verilog/aeis_pkg.sv
// aeis_pkg: register map, field positions and carrier types for the
// per-axis error, interrupt-factor and input-level status block.
// assumes an apb master on pclk and a motion core on the same clock.
//
// Summary of operation
// R1 - any error bit 0..6 set raises that axis error flag in main status
// R2 - bit 0 sets on positive drive when position reaches positive compare
// R3 - bit 1 sets on negative drive when position at or below negative compare
// R4 - bits 2 and 3 set while positive or negative hard limit is active
// R5 - bit 4 sets while servo alarm input is at its configured active level
// R6 - bit 5 sets when active-low emergency input is low
// R7 - bit 6, x axis of main chip only, sets on any sub chip error
// R8 - an active limit while driving ends pulses, decelerating or immediately
// R9 - soft limit bits never set while driving in the opposite direction
// R10 - reads return the copy of the most recently selected axis
// R11 - host selects the read axis with command 0f, nothing else happens; the code selects on any command code whose axis bits [9:8] are nonzero
// R12 - latched errors hold until next drive command or clear command 25h
// R13 - host enables each interrupt factor separately; disabled ones stay quiet
// R14 - factor bits 1..4 latch on the four compare crossings
// R15 - bit 5 on cruise end, bit 6 on cruise begin, bit 7 on drive end
// R16 - an enabled factor sets its bit and pulls the interrupt output low
// R17 - reading the interrupting axis factor register clears it, output high
// R18 - with 8-bit bus, reading the low byte clears all factor bits
// R19 - input level bits read 0 for a low pin and 1 for a high pin
// R20 - input level layout: stops, emergency, ext drive, inpos, alarm, gp, limits
// R21 - inputs other than limits readable as general inputs when unused
// R22 - interrupt output stays low while any enabled factor of either axis is set
`default_nettype none
package aeis_pkg;
   localparam int unsigned AEIS_AXES = 2;
   // register byte addresses
   localparam logic [7:0] AEIS_ERR_ADDR   = 8'h00;
   localparam logic [7:0] AEIS_IRQF_ADDR  = 8'h04;
   localparam logic [7:0] AEIS_XIN_ADDR   = 8'h08;
   localparam logic [7:0] AEIS_YIN_ADDR   = 8'h0c;
   localparam logic [7:0] AEIS_CMD_ADDR   = 8'h10;
   localparam logic [7:0] AEIS_IEN_ADDR   = 8'h14;
   localparam logic [7:0] AEIS_CFG_ADDR   = 8'h18;
   localparam logic [7:0] AEIS_MAIN_ADDR  = 8'h1c;
   // command register fields: [7:0] code, [9:8] axis assignment
   localparam logic [7:0] AEIS_CMD_AXIS_SEL = 8'h0f;
   localparam logic [7:0] AEIS_CMD_CLEAR    = 8'h25;
   localparam logic [7:0] AEIS_CMD_DRV_LO   = 8'h20;
   localparam logic [7:0] AEIS_CMD_DRV_HI   = 8'h23;
   localparam int unsigned AEIS_CMD_AX_LSB  = 8;
   // config register per axis byte: bit0 alarm active high, bit1 sl enable,
   // bit2 limit active high, bit3 immediate stop on limit
   localparam int unsigned AEIS_CFG_ALM_HI  = 0;
   localparam int unsigned AEIS_CFG_SL_EN   = 1;
   localparam int unsigned AEIS_CFG_LMT_HI  = 2;
   localparam int unsigned AEIS_CFG_LMT_IMM = 3;
   // error bit positions
   localparam int unsigned AEIS_E_SLP  = 0;
   localparam int unsigned AEIS_E_SLN  = 1;
   localparam int unsigned AEIS_E_HLP  = 2;
   localparam int unsigned AEIS_E_HLN  = 3;
   localparam int unsigned AEIS_E_ALM  = 4;
   localparam int unsigned AEIS_E_EMG  = 5;
   localparam int unsigned AEIS_E_SUB  = 6;
   localparam logic [15:0] AEIS_ERR_RST  = 16'h0000;
   localparam logic [15:0] AEIS_IRQF_RST = 16'h0000;
   localparam logic [7:0]  AEIS_IEN_RST  = 8'h00;
   localparam logic [7:0]  AEIS_CFG_RST  = 8'h00;
   localparam logic [31:0] AEIS_UNMAPPED = 32'h0000_0000;

   // events and levels from the motion core for one axis
   typedef struct packed {
      logic        drv_pos;      // driving in + direction
      logic        drv_neg;      // driving in - direction
      logic        ge_cpos;      // position >= positive compare
      logic        le_cneg;      // position <= negative compare
      logic        gt_cneg_evt;  // crossed above negative compare
      logic        lt_cneg_evt;  // crossed below negative compare
      logic        lt_cpos_evt;  // crossed below positive compare
      logic        gt_cpos_evt;  // crossed above positive compare
      logic        cruise_end_evt;
      logic        cruise_begin_evt;
      logic        drive_done_evt;
   } aeis_core_t;

   // raw input pins for one axis
   typedef struct packed {
      logic [5:0] general_input;     // general inputs 5..0
      logic       neg_limit_input;
      logic       pos_limit_input;
      logic       servo_fault_input;
      logic       in_position_input;
      logic       ext_drive_neg_input;
      logic       ext_drive_pos_input;
      logic [2:0] stop_input;        // stop inputs 2..0
   } aeis_pins_t;

   // stop request back to the pulse generator
   typedef struct packed {
      logic decel;
      logic sudden;
   } aeis_stop_t;
endpackage
`default_nettype wire

// file: testbench/aeis_status_properties.sv
// aeis_status_properties: apb, error flag, interrupt and input checks.
// assumes pins and halt stay stable some cycles before a level read.
`default_nettype none
module aeis_status_properties
   import aeis_pkg::*;
(
   input wire logic             pclk,                 // clock
   input wire logic             presetn,              // reset, low
   input wire logic             psel,                 // select
   input wire logic             penable,              // access
   input wire logic             pwrite,               // direction
   input wire logic [7:0]       paddr,                // address
   input wire logic [31:0]      prdata,               // read data
   input wire logic             pready,               // ready
   input wire logic             pslverr,              // error
   input wire aeis_core_t [1:0] core,                 // core events
   input wire aeis_pins_t [1:0] pins,                 // raw pins
   input wire logic             emergency_halt_input, // halt, low
   input wire logic [1:0]       axis_err_flag,        // error flags
   input wire logic             irq_out_low           // interrupt, low
);
   timeunit 1ns;
   timeprecision 1ps;
   aeis_pins_t [1:0] pins_q;
   logic             halt_q;
   logic [2:0]       pin_age;
   wire logic evt_any = (|core[0][6:0]) | (|core[1][6:0]);
   wire logic rd_irqf = pready && !pwrite && paddr == AEIS_IRQF_ADDR;
   wire logic rd_lvl  = pready && !pwrite && pin_age >= 3'd5;

   function automatic logic [15:0] lv(input aeis_pins_t p, input logic h);
      return {p[8], p[7], p[14:9], p[6:3], h, p[2:0]};
   endfunction

   // cycles since any pin or the halt input last moved
   always_ff @(posedge pclk)
   begin
      pins_q <= pins;
      halt_q <= emergency_halt_input;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pin_age <= 3'd0;
      else if (pins != pins_q || emergency_halt_input != halt_q)
         pin_age <= 3'd0;
      else if (pin_age != 3'd7)
         pin_age <= pin_age + 3'd1;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("no ready in access phase");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_unmapped_err: assert property (pready && !pwrite &&
      paddr > AEIS_MAIN_ADDR |-> pslverr && prdata == AEIS_UNMAPPED)
      else $error("unmapped read not refused");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 0)
      else $error("upper read bits not zero");
   a_halt_flags: assert property
      (!emergency_halt_input [*8] |-> axis_err_flag == 2'b11)
      else $error("halt did not raise both error flags");
   a_x_levels: assert property (rd_lvl && paddr == AEIS_XIN_ADDR
      |-> prdata[15:0] == lv(pins[0], emergency_halt_input))
      else $error("x input levels wrong");
   a_y_levels: assert property (rd_lvl && paddr == AEIS_YIN_ADDR
      |-> prdata[15:0] == lv(pins[1], 1'b0))
      else $error("y input levels wrong");
   a_irq_cause: assert property ($fell(irq_out_low) |->
      $past(evt_any, 1) || $past(evt_any, 2) || $past(evt_any, 3))
      else $error("interrupt without an event");
   a_irq_release: assert property ($rose(irq_out_low) |->
      $past(rd_irqf, 1) || $past(rd_irqf, 2))
      else $error("interrupt released without a factor read");
endmodule

bind aeis_status aeis_status_properties u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .core(core), .pins(pins),
   .emergency_halt_input(emergency_halt_input),
   .axis_err_flag(axis_err_flag), .irq_out_low(irq_out_low));
`default_nettype wire

// file: testbench/aeis_host.sv
// aeis_host: host processor model, an apb master with register tasks.
// assumes a slave that answers with pready; the bench bounds any hang.
`default_nettype none
module aeis_host
   import aeis_pkg::*;
(
   input  wire logic        pclk,    // clock
   output logic             psel,    // select
   output logic             penable, // access
   output logic             pwrite,  // direction
   output logic [7:0]       paddr,   // address
   output logic [31:0]      pwdata,  // write data
   output logic [3:0]       pstrb,   // byte strobes
   input  wire logic [31:0] prdata,  // read data
   input  wire logic        pready,  // ready
   input  wire logic        pslverr  // error
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] dd;
   logic        de;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
   end

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] wd);
      xfer(1'b1, a, wd, dd, de);
   endtask
   task sel(input logic [1:0] ax);
      wr(AEIS_CMD_ADDR, {22'h0, ax, AEIS_CMD_AXIS_SEL});
   endtask
   task en(input logic [15:0] f);
      wr(AEIS_IEN_ADDR, {16'h0, f});
   endtask
endmodule
`default_nettype wire

// file: testbench/axis_error_irq_input_status_test.sv
// axis_error_irq_input_status_test: register level tests of aeis_status.
// assumes the host model for bus cycles and a 25 mhz clock.
`default_nettype none
module axis_error_irq_input_status_test
   import aeis_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata, d;
   logic [3:0]       pstrb;
   aeis_core_t [1:0] core;
   aeis_pins_t [1:0] pins;
   aeis_stop_t [1:0] stop_req;
   logic [1:0]       axis_err_flag;
   logic             halt_n, sub, main_chip, bus8, irq_out_low;
   logic [29:0]      pat;
   int               n_errors, tests_run, cycles;
   logic [3:0]       sl_in [4] = '{4'h6, 4'h9, 4'ha, 4'h5};
   logic [31:0]      sl_ex [4] = '{32'h0, 32'h0, 32'h1, 32'h2};

   aeis_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core(core), .pins(pins), .emergency_halt_input(halt_n),
      .subchip_fault_in(sub), .is_main_chip(main_chip), .bus8_mode(bus8),
      .stop_req(stop_req), .axis_err_flag(axis_err_flag),
      .irq_out_low(irq_out_low));
   aeis_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         end_of_test;
      end
   end

   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
   begin
      tests_run++;
      if (got !== ex)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, ex, got);
      end
   end
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
   begin
      u_host.xfer(1'b0, a, 32'h0, d, e);
      chk(nm, ex, d);
   end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task pulse(input int ax, input int b);
   begin
      core[ax][b] <= 1'b1;
      cyc(1);
      core[ax][b] <= 1'b0;
      cyc(3);
   end
   endtask
   function automatic logic [15:0] lv(input aeis_pins_t p, input logic h);
      return {p[8], p[7], p[14:9], p[6:3], h, p[2:0]};
   endfunction
   task end_of_test;
   begin
      $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 1'b0;
      core = '0;
      pins = '1;
      halt_n = 1'b1;
      sub = 1'b0;
      main_chip = 1'b0;
      bus8 = 1'b0;
      n_errors = 0;
      tests_run = 0;
      cycles = 0;
      cyc(2);
      presetn <= 1'b1;
      rdc("err", AEIS_ERR_ADDR, {16'h0, AEIS_ERR_RST});
      rdc("irqf", AEIS_IRQF_ADDR, {16'h0, AEIS_IRQF_RST});
      rdc("main", AEIS_MAIN_ADDR, 32'h0);
      u_host.xfer(1'b0, 8'h40, 32'h0, d, e);
      chk("slverr", 32'h1, {31'h0, e});
      chk("unmapped", AEIS_UNMAPPED, d);
      $display("test reset finished");
      for (int i = 0; i < 2; i++)
      begin
         pat = i ? 30'h2aaa_aaaa : 30'h1555_5555;
         pins <= pat;
         halt_n <= i[0];
         cyc(10);
         rdc("xin", AEIS_XIN_ADDR, {16'h0, lv(pat[14:0], i[0])});
         rdc("yin", AEIS_YIN_ADDR, {16'h0, lv(pat[29:15], 1'b0)});
      end
      pins <= '1;
      halt_n <= 1'b0;
      cyc(10);
      halt_n <= 1'b1;
      cyc(6);
      rdc("main", AEIS_MAIN_ADDR, 32'h3);
      u_host.wr(AEIS_CMD_ADDR, 32'h225);
      rdc("err_y", AEIS_ERR_ADDR, 32'h0);
      u_host.sel(2'b01);
      rdc("err_x", AEIS_ERR_ADDR, 32'h3c);
      u_host.wr(AEIS_CMD_ADDR, 32'h125);
      rdc("err_x", AEIS_ERR_ADDR, 32'h0);
      $display("test levels and halt finished");
      pins[1].pos_limit_input <= 1'b0;
      core[1].drv_pos <= 1'b1;
      cyc(6);
      chk("stop_y", 32'h2, {30'h0, stop_req[1]});
      u_host.wr(AEIS_CFG_ADDR, 32'h0800);
      cyc(2);
      chk("stop_y", 32'h1, {30'h0, stop_req[1]});
      pins[1].neg_limit_input <= 1'b0;
      pins[1].servo_fault_input <= 1'b0;
      cyc(6);
      u_host.sel(2'b10);
      rdc("err_y", AEIS_ERR_ADDR, 32'h1c);
      pins <= '1;
      core <= '0;
      u_host.wr(AEIS_CFG_ADDR, 32'h0100);
      cyc(6);
      rdc("err_y", AEIS_ERR_ADDR, 32'h1c);
      u_host.wr(AEIS_CFG_ADDR, 32'h0002);
      u_host.wr(AEIS_CMD_ADDR, 32'h125);
      for (int i = 0; i < 4; i++)
      begin
         core[0][10:7] <= sl_in[i];
         cyc(3);
         rdc("err_x", AEIS_ERR_ADDR, sl_ex[i]);
         core <= '0;
         u_host.wr(AEIS_CMD_ADDR, 32'h120);
      end
      main_chip <= 1'b1;
      sub <= 1'b1;
      cyc(3);
      rdc("err_x", AEIS_ERR_ADDR, 32'h40);
      sub <= 1'b0;
      $display("test limits finished");
      u_host.en(16'h00fe);
      for (int i = 0; i < 7; i++)
      begin
         pulse(0, 6 - i);
         chk("irq", 32'h0, {31'h0, irq_out_low});
         rdc("irqf_x", AEIS_IRQF_ADDR, 32'h2 << i);
         cyc(2);
         chk("irq", 32'h1, {31'h0, irq_out_low});
      end
      pulse(1, 0);
      chk("irq", 32'h1, {31'h0, irq_out_low});
      u_host.en(16'hfefe);
      pulse(1, 0);
      pulse(0, 0);
      bus8 <= 1'b1;
      rdc("irqf_x", AEIS_IRQF_ADDR, 32'h80);
      chk("irq", 32'h0, {31'h0, irq_out_low});
      u_host.sel(2'b10);
      rdc("irqf_y", AEIS_IRQF_ADDR, 32'h80);
      cyc(2);
      chk("irq", 32'h1, {31'h0, irq_out_low});
      $display("test interrupts finished");
      end_of_test;
   end
endmodule
`default_nettype wire
